// File: core/pmpc_checker.v
/*
 * Physical memory protection checker of one hart: sixteen entries, a machine-mode
 * register port and a per-access check port. Assumes requests come from the
 * hart's pipeline on the same clock and that the pipeline turns a fault into a
 * precise trap on the instruction that issued the access.
 * The grain is sixteen bytes, so the four-byte mode cannot be selected, and
 * access ranges that wrap past the top of the physical space are not handled.
 */
//
// Behaviour
// - Check supervisor and user accesses, and modified-privilege machine data accesses.
// - Page-table walk accesses are checked as supervisor accesses.
// - Violations are reported precisely with the offending access.
// - Each entry is an 8-bit configuration and one address register; 16 entries.
// - Registers writable only from machine mode; written fields are legalized.
// - Configurations packed four per register, four registers on 32-bit harts.
// - Address register holds physical address bits 33 to 2.
// - Permission bits grant access; read clear with write set never stored.
// - Missing execute, read or write permission gives matching fault class.
// - Mode field: off, top-of-range, four-byte aligned, power-of-two aligned.
// - Power-of-two size is decoded from trailing ones of the address.
// - Top-of-range spans previous address up to own; entry 0 from zero.
// - Top-of-range with lower bound not below top matches nothing.
// - One grain for all entries; coarse grain forbids four-byte mode.
// - Address read-back forces grain bits according to mode.
// - Mode changes keep the stored address bits intact.
// - Address registers are zero-extended for matching.
// - Lock ignores writes to entry, and to previous address under top-of-range.
// - Locked entries bind machine mode; unlocked ones let machine mode pass.
// - Lowest matching entry decides; partial coverage fails.
// - No match: machine passes, supervisor and user fail.
// - Any failing access of an instruction faults the instruction.
`timescale 1ns/10ps
`default_nettype none
`include "pmpc_map.vh"

module pmpc_checker (
  // Clock, reset, enable
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire ce_i,
  // Control register port
  input wire csr_we_i,
  input wire csr_re_i,
  input wire [1:0] csr_priv_i,
  input wire [6:0] csr_addr_i,
  input wire [31:0] csr_wdata_i,
  output reg [31:0] csr_rdata_o,
  output reg csr_rvalid_o,
  output reg csr_illegal_o,
  // Access request
  input wire req_valid_i,
  input wire req_first_i,
  input wire [33:0] req_addr_i,
  input wire [1:0] req_size_i,
  input wire [1:0] req_type_i,
  input wire [1:0] req_priv_i,
  input wire req_modify_privilege_bit_i,
  input wire [1:0] req_mpp_i,
  input wire req_ptw_i,
  // Check result
  output reg rsp_valid_o,
  output reg rsp_allow_o,
  output reg [2:0] rsp_fault_o,
  output reg rsp_insn_fault_o
);

  localparam N = `PMPC_NUM_ENTRIES;

  wire [8*N-1:0] cfg_all;
  wire [32*N-1:0] addr_all;
  wire [32*N-1:0] addr_rd_all;
  wire [N-1:0] hit_any;
  wire [N-1:0] hit_all;
  wire [N-1:0] tor_lock;
  wire csr_m;
  wire [3:0] size_m1;
  wire [33:0] acc_hi;
  wire csr_rd_ok;
  wire csr_bad;

  reg [1:0] eff_priv;
  reg [31:0] rd_data;
  reg rd_mapped;
  reg [6:0] rd_idx;
  reg found;
  reg [3:0] sel;
  reg [7:0] sel_cfg;
  reg perm;
  reg allow;
  reg [2:0] fault_vec;
  reg insn_fault_d;
  reg insn_fault_q;

  // True when the index falls in the configuration block at register k
  function cfg_hit;
    input [6:0] a;
    input integer k;
    begin
      cfg_hit = (a == (`PMPC_CFG_BASE + k[6:0]));
    end
  endfunction

  // True when the index selects address register k
  function addr_hit;
    input [6:0] a;
    input integer k;
    begin
      addr_hit = (a == (`PMPC_ADDR_BASE + k[6:0]));
    end
  endfunction

  // True when the index lies in a block; widened so base plus span cannot wrap
  function in_block;
    input [6:0] a;
    input [6:0] base;
    input [6:0] span;
    reg [7:0] top;
    begin
      top = {1'b0, base} + {1'b0, span};
      in_block = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
    end
  endfunction

  // Only machine mode may touch the registers
  assign csr_m = (csr_priv_i == `PMPC_PRIV_M);
  // Accepted read and refused access of the register port
  assign csr_rd_ok = csr_re_i && csr_m && rd_mapped;
  assign csr_bad = (csr_re_i || csr_we_i) && (!csr_m || !rd_mapped);

  // Byte range of the access
  assign size_m1 = (4'h1 << req_size_i) - 4'h1;
  assign acc_hi = req_addr_i + {30'h0, size_m1};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_entry
      wire [31:0] prev_addr;

      // Entry 0 takes zero as its lower bound
      if (gi == 0) begin : g_first
        assign prev_addr = 32'h0000_0000;
      end else begin : g_rest
        assign prev_addr = addr_all[32*gi-1 -: 32];
      end

      // Locked top-of-range entry guards the address below it
      if (gi == N - 1) begin : g_last
        assign tor_lock[gi] = 1'b0;
      end else begin : g_mid
        assign tor_lock[gi] = cfg_all[8*(gi+1)+`PMPC_CFG_L] &&
                              (cfg_all[8*(gi+1)+4 -: 2] == `PMPC_MODE_TOR);
      end

      // Four configuration bytes per register
      pmpc_entry_regs u_regs (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .cfg_we_i(csr_we_i && csr_m && cfg_hit(csr_addr_i, gi / 4)),
        .cfg_wdata_i(csr_wdata_i[8*(gi%4) +: 8]),
        .addr_we_i(csr_we_i && csr_m && addr_hit(csr_addr_i, gi)),
        .addr_wdata_i(csr_wdata_i),
        .next_tor_lock_i(tor_lock[gi]),
        .cfg_o(cfg_all[8*gi +: 8]),
        .addr_o(addr_all[32*gi +: 32]),
        .addr_rd_o(addr_rd_all[32*gi +: 32])
      );

      // Every entry compared at once
      pmpc_entry_match u_match (
        .mode_i(cfg_all[8*gi+4 -: 2]),
        .addr_cur_i(addr_all[32*gi +: 32]),
        .addr_prev_i(prev_addr),
        .acc_lo_i(req_addr_i),
        .acc_hi_i(acc_hi),
        .any_o(hit_any[gi]),
        .all_o(hit_all[gi])
      );
    end
  endgenerate

  // Register read mux; unimplemented entries read as zero
  always @* begin
    rd_data = 32'h0000_0000;
    rd_mapped = 1'b1;
    rd_idx = 7'h00;
    if (in_block(csr_addr_i, `PMPC_CFG_BASE, `PMPC_CFG_SPAN)) begin
      rd_idx = csr_addr_i - `PMPC_CFG_BASE;
      if (rd_idx < `PMPC_NUM_CFG_CSRS) begin
        rd_data = cfg_all[{rd_idx[1:0], 5'h00} +: 32];
      end
    end else if (in_block(csr_addr_i, `PMPC_ADDR_BASE, `PMPC_ADDR_SPAN)) begin
      rd_idx = csr_addr_i - `PMPC_ADDR_BASE;
      if (rd_idx < N) begin
        rd_data = addr_rd_all[{rd_idx[3:0], 5'h00} +: 32];
      end
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // Effective privilege of the access
  // Fetches ignore the modify-privilege bit; page walks always count as supervisor
  always @* begin
    if (req_ptw_i) begin
      eff_priv = `PMPC_PRIV_S;
    end else if ((req_type_i != `PMPC_ACC_FETCH) && (req_priv_i == `PMPC_PRIV_M) &&
                 req_modify_privilege_bit_i) begin
      eff_priv = req_mpp_i;
    end else begin
      eff_priv = req_priv_i;
    end
  end

  // Static priority: lowest-numbered entry touching any byte
  // Scanned from the top so that the lowest-numbered hit is the one kept
  always @* begin : p_prio
    integer i;
    i = 0;
    found = 1'b0;
    sel = 4'h0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (hit_any[i]) begin
        found = 1'b1;
        sel = i[3:0];
      end
    end
  end

  // Decision and instruction fault
  always @* begin
    sel_cfg = cfg_all[{sel, 3'h0} +: 8];
    case (req_type_i)
      `PMPC_ACC_FETCH: perm = sel_cfg[`PMPC_CFG_X];
      `PMPC_ACC_LOAD: perm = sel_cfg[`PMPC_CFG_R];
      default: perm = sel_cfg[`PMPC_CFG_W];
    endcase
    if (!found) begin
      allow = (eff_priv == `PMPC_PRIV_M);
    end else if (!hit_all[sel]) begin
      allow = 1'b0;
    end else if (!sel_cfg[`PMPC_CFG_L] && (eff_priv == `PMPC_PRIV_M)) begin
      allow = 1'b1;
    end else begin
      allow = perm;
    end
    // Earlier failing part of the same instruction still faults it
    insn_fault_d = !allow || (insn_fault_q && !req_first_i);
  end

  // Fault class follows the access type
  always @* begin
    fault_vec = 3'h0;
    if (!allow) begin
      case (req_type_i)
        `PMPC_ACC_FETCH: fault_vec[`PMPC_FAULT_INSTR] = 1'b1;
        `PMPC_ACC_LOAD: fault_vec[`PMPC_FAULT_LOAD] = 1'b1;
        default: fault_vec[`PMPC_FAULT_STORE] = 1'b1;
      endcase
    end
  end

  // Register port answer, one cycle after the strobe
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      csr_rdata_o <= 32'h0000_0000;
      csr_rvalid_o <= 1'b0;
      csr_illegal_o <= 1'b0;
    end else if (ce_i) begin
      csr_rvalid_o <= csr_rd_ok;
      // Zero outside an answer so stale entries never show on the bus
      csr_rdata_o <= csr_rd_ok ? rd_data : 32'h0000_0000;
      // Lower modes and unmapped indices trap as illegal
      csr_illegal_o <= csr_bad;
    end
  end

  // Check answer; result pairs with the request one cycle earlier
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_allow_o <= 1'b0;
      rsp_fault_o <= 3'h0;
      rsp_insn_fault_o <= 1'b0;
      insn_fault_q <= 1'b0;
    end else if (ce_i) begin
      rsp_valid_o <= req_valid_i;
      if (req_valid_i) begin
        rsp_allow_o <= allow;
        rsp_fault_o <= fault_vec;
        rsp_insn_fault_o <= insn_fault_d;
        insn_fault_q <= insn_fault_d;
      end else begin
        rsp_allow_o <= 1'b0;
        rsp_fault_o <= 3'h0;
        rsp_insn_fault_o <= 1'b0;
      end
    end
  end

endmodule // pmpc_checker
`default_nettype wire

// File: core/pmpc_entry_match.v
/*
 * Address matcher of one protection entry: tells whether an access touches any
 * byte of the entry's region and whether the region covers all its bytes.
 * Purely combinational; assumes the access range does not wrap past the top.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pmpc_map.vh"

module pmpc_entry_match (
  // Entry setting
  input wire [1:0] mode_i,
  input wire [31:0] addr_cur_i,
  input wire [31:0] addr_prev_i,
  // Access byte range
  input wire [33:0] acc_lo_i,
  input wire [33:0] acc_hi_i,
  // Result
  output reg any_o,
  output reg all_o
);

  wire [31:0] power_of_two_aligned_mode_word;
  wire [31:0] power_of_two_aligned_mode_mask;
  wire [31:0] power_of_two_aligned_mode_base;
  wire [33:0] reg_lo;
  wire [33:0] reg_hi;
  wire [31:0] tor_bot;
  wire [31:0] tor_top;
  wire [33:0] tor_lo;
  wire [33:0] tor_hi;

  // Grain forces low bits to one; trailing ones give the size
  assign power_of_two_aligned_mode_word = addr_cur_i | `PMPC_POWER_OF_TWO_ALIGNED_MODE_ONES;
  assign power_of_two_aligned_mode_mask = (mode_i == `PMPC_MODE_NA4) ? 32'h0 : (power_of_two_aligned_mode_word ^ (power_of_two_aligned_mode_word + 32'h1));
  assign power_of_two_aligned_mode_base = power_of_two_aligned_mode_word & ~power_of_two_aligned_mode_mask;
  // Zero extension to the physical width
  assign reg_lo = {power_of_two_aligned_mode_base, 2'h0};
  assign reg_hi = {power_of_two_aligned_mode_base | power_of_two_aligned_mode_mask, 2'h3};
  // Low grain bits play no part in range bounds
  assign tor_bot = addr_prev_i & ~`PMPC_TOR_ZEROS;
  assign tor_top = addr_cur_i & ~`PMPC_TOR_ZEROS;
  assign tor_lo = {tor_bot, 2'h0};
  assign tor_hi = {tor_top, 2'h0};

  always @* begin
    any_o = 1'b0;
    all_o = 1'b0;
    case (mode_i)
      `PMPC_MODE_TOR: begin
        // Empty or inverted range matches nothing
        if (tor_bot < tor_top) begin
          any_o = (acc_hi_i >= tor_lo) && (acc_lo_i < tor_hi);
          all_o = (acc_lo_i >= tor_lo) && (acc_hi_i < tor_hi);
        end
      end
      `PMPC_MODE_NA4, `PMPC_MODE_POWER_OF_TWO_ALIGNED_MODE: begin
        any_o = (acc_hi_i >= reg_lo) && (acc_lo_i <= reg_hi);
        all_o = (acc_lo_i >= reg_lo) && (acc_hi_i <= reg_hi);
      end
      default: begin
        // Disabled entry
        any_o = 1'b0;
        all_o = 1'b0;
      end
    endcase
  end

endmodule // pmpc_entry_match
`default_nettype wire

// File: core/pmpc_entry_regs.v
/*
 * Storage of one protection entry: configuration byte and address register,
 * with lock handling, legalization of written values and the read-back view.
 * Assumes writes arrive already qualified by machine mode.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pmpc_map.vh"

module pmpc_entry_regs (
  // Clock, reset, enable
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire ce_i,
  // Writes
  input wire cfg_we_i,
  input wire [7:0] cfg_wdata_i,
  input wire addr_we_i,
  input wire [31:0] addr_wdata_i,
  input wire next_tor_lock_i,
  // State
  output wire [7:0] cfg_o,
  output wire [31:0] addr_o,
  output wire [31:0] addr_rd_o
);

  reg [7:0] cfg_q;
  reg [31:0] addr_q;
  wire locked;
  wire [2:0] rwx_d;
  wire [1:0] mode_d;

  assign locked = cfg_q[`PMPC_CFG_L];
  // Reserved read clear / write set combination keeps the old value
  assign rwx_d = (cfg_wdata_i[1:0] == 2'h2) ? cfg_q[2:0] : cfg_wdata_i[2:0];
  // Four-byte mode unavailable with a coarse grain
  assign mode_d = ((cfg_wdata_i[4:3] == `PMPC_MODE_NA4) && (`PMPC_G >= 1)) ?
                  cfg_q[4:3] : cfg_wdata_i[4:3];

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= `PMPC_CFG_RESET;
      addr_q <= `PMPC_ADDR_RESET;
    end else if (ce_i) begin
      // Locked entry ignores writes until reset, even when off
      if (cfg_we_i && !locked) begin
        cfg_q <= {cfg_wdata_i[7], 2'h0, mode_d, rwx_d};
      end
      if (addr_we_i && !locked && !next_tor_lock_i) begin
        addr_q <= addr_wdata_i;
      end
    end
  end

  assign cfg_o = cfg_q;
  assign addr_o = addr_q;
  // Mode changes alter only the view, never the stored bits
  assign addr_rd_o = cfg_q[`PMPC_CFG_A_HI] ? (addr_q | `PMPC_POWER_OF_TWO_ALIGNED_MODE_ONES) :
                     (addr_q & ~`PMPC_TOR_ZEROS);

endmodule // pmpc_entry_regs
`default_nettype wire

// File: core/pmpc_map.vh
/*
 * Constants for the memory protection checker: entry count, grain, configuration
 * field positions, matching modes, privilege codes, access types and register
 * index map. Assumes a hart with a 32-bit register width and 34-bit physical addresses.
 */
`ifndef PMPC_MAP_VH
`define PMPC_MAP_VH

// Entries implemented (lowest-numbered first) and platform grain G
`define PMPC_NUM_ENTRIES 16
`define PMPC_NUM_CFG_CSRS 4
`define PMPC_G 2
// Address bits forced to one (power-of-two mode) and to zero (off or top-of-range)
`define PMPC_POWER_OF_TWO_ALIGNED_MODE_ONES ((32'h1 << (`PMPC_G - 1)) - 32'h1)
`define PMPC_TOR_ZEROS ((32'h1 << `PMPC_G) - 32'h1)

// Configuration byte layout
`define PMPC_CFG_R 0
`define PMPC_CFG_W 1
`define PMPC_CFG_X 2
`define PMPC_CFG_A_LO 3
`define PMPC_CFG_A_HI 4
`define PMPC_CFG_L 7
`define PMPC_CFG_RESET 8'h00
`define PMPC_ADDR_RESET 32'h0000_0000

// Matching modes
`define PMPC_MODE_OFF 2'h0
`define PMPC_MODE_TOR 2'h1
`define PMPC_MODE_NA4 2'h2
`define PMPC_MODE_POWER_OF_TWO_ALIGNED_MODE 2'h3

// Privilege codes
`define PMPC_PRIV_U 2'h0
`define PMPC_PRIV_S 2'h1
`define PMPC_PRIV_M 2'h3

// Access types and fault vector bits
`define PMPC_ACC_FETCH 2'h0
`define PMPC_ACC_LOAD 2'h1
`define PMPC_ACC_STORE 2'h2
`define PMPC_FAULT_INSTR 0
`define PMPC_FAULT_LOAD 1
`define PMPC_FAULT_STORE 2

// Register index map on the control port
`define PMPC_CFG_BASE 7'h00
`define PMPC_CFG_SPAN 7'h10
`define PMPC_ADDR_BASE 7'h40
`define PMPC_ADDR_SPAN 7'h40

`endif

// File: dv/pmpc_checker_asserts.sv
/* Port checker of the protection checker.
   Assumes one clock domain; bound into pmpc_checker. */
`timescale 1ns/10ps
`default_nettype none
module pmpc_checker_asserts (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Register port
  input wire logic csr_we_i,
  input wire logic csr_re_i,
  input wire logic [1:0] csr_priv_i,
  input wire logic [6:0] csr_addr_i,
  input wire logic [31:0] csr_rdata_o,
  input wire logic csr_rvalid_o,
  input wire logic csr_illegal_o,
  // Check port
  input wire logic req_valid_i,
  input wire logic req_first_i,
  input wire logic [1:0] req_type_i,
  input wire logic rsp_valid_o,
  input wire logic rsp_allow_o,
  input wire logic [2:0] rsp_fault_o,
  input wire logic rsp_insn_fault_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic first_q;
  logic acc_q;
  // Failures since the last first access
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      first_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      if (ce_i && req_valid_i) first_q <= req_first_i;
      if (ce_i && rsp_valid_o) acc_q <= (!first_q && acc_q) || !rsp_allow_o;
    end
  end
  a_rsp_next_cycle: assert property (ce_i && req_valid_i |=> rsp_valid_o)
    else $error("response missing after request");
  a_rsp_has_cause: assert property (rsp_valid_o |-> $past(req_valid_i))
    else $error("response without request");
  a_fault_by_type: assert property (ce_i && req_valid_i && req_type_i != 2'h3 |=>
    (rsp_allow_o ? rsp_fault_o == 3'h0 : rsp_fault_o == (3'h1 << $past(req_type_i))))
    else $error("fault class wrong");
  a_idle_quiet: assert property (!rsp_valid_o |-> !rsp_allow_o && rsp_fault_o == 3'h0)
    else $error("result outside response");
  a_insn_accum: assert property (rsp_valid_o |->
    rsp_insn_fault_o == ((!first_q && acc_q) || !rsp_allow_o))
    else $error("instruction fault wrong");
  a_csr_non_machine: assert property (ce_i && (csr_we_i || csr_re_i) &&
    csr_priv_i != 2'h3 |=> csr_illegal_o && !csr_rvalid_o)
    else $error("low privilege access accepted");
  a_csr_read_ok: assert property (ce_i && csr_re_i && csr_priv_i == 2'h3 &&
    (csr_addr_i < 7'h10 || csr_addr_i[6]) |=> csr_rvalid_o && !csr_illegal_o)
    else $error("mapped read refused");
  a_unmapped_bad: assert property (ce_i && csr_re_i && csr_addr_i[6:4] inside {3'h1,
    3'h2, 3'h3} |=> csr_illegal_o && !csr_rvalid_o)
    else $error("unmapped read accepted");
  a_rdata_quiet: assert property (!csr_rvalid_o |-> csr_rdata_o == 32'h0)
    else $error("read data outside answer");
endmodule // pmpc_checker_asserts
bind pmpc_checker pmpc_checker_asserts u_pmpc_checker_asserts (.clk_sys_i, .sys_rst_i,
  .ce_i, .csr_we_i, .csr_re_i, .csr_priv_i, .csr_addr_i, .csr_rdata_o, .csr_rvalid_o,
  .csr_illegal_o, .req_valid_i, .req_first_i, .req_type_i, .rsp_valid_o, .rsp_allow_o,
  .rsp_fault_o, .rsp_insn_fault_o);
`default_nettype wire

// File: dv/pmpc_hart_model.sv
/* Hart pipeline model: issues one access, returns its result.
   Assumes the checker answers one cycle after taking it. */
`timescale 1ns/10ps
`default_nettype none
`include "pmpc_map.vh"
module pmpc_hart_model (
  // Clock
  input wire logic clk_sys_i,
  // Requests
  output logic req_valid_o,
  output logic req_first_o,
  output logic [33:0] req_addr_o,
  output logic [1:0] req_size_o,
  output logic [1:0] req_type_o,
  output logic [1:0] req_priv_o,
  output logic req_modify_privilege_bit_o,
  output logic [1:0] req_mpp_o,
  output logic req_ptw_o,
  // Answers
  input wire logic rsp_valid_i,
  input wire logic rsp_allow_i,
  input wire logic [2:0] rsp_fault_i,
  input wire logic rsp_insn_fault_i
);
  initial {req_valid_o, req_first_o, req_addr_o, req_size_o, req_type_o, req_priv_o,
    req_modify_privilege_bit_o, req_mpp_o, req_ptw_o} = '0;
  // Result: valid, allow, fault, instruction fault
  task automatic access(input logic [33:0] a, input logic [1:0] sz, input logic [1:0] ty,
    input logic [1:0] pv, input logic mp, input logic pt, input logic fi,
    output logic [5:0] r);
    @(posedge clk_sys_i);
    #1;
    {req_valid_o, req_first_o, req_addr_o, req_size_o} = {1'b1, fi, a, sz};
    {req_type_o, req_priv_o, req_modify_privilege_bit_o, req_ptw_o} = {ty, pv, mp, pt};
    req_mpp_o = `PMPC_PRIV_U;
    @(posedge clk_sys_i);
    #1;
    r = {rsp_valid_i, rsp_allow_i, rsp_fault_i, rsp_insn_fault_i};
    req_valid_o = 1'b0;
    // Released address no longer holds its value
    req_addr_o = ~req_addr_o;
  endtask
endmodule // pmpc_hart_model
`default_nettype wire

// File: dv/testbench.sv
/* Self-checking bench of the protection checker.
   Assumes the hart model drives the check port. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct {logic [15:0] c; logic [31:0] a0; logic [31:0] a1; logic [33:0] ad;
    logic [1:0] sz; logic [1:0] ty; logic [1:0] pv; logic mp; logic pt; logic ok;} pmpc_row_t;
  logic clk_sys_i, sys_rst_i, ce_i, csr_we_i, csr_re_i, csr_rvalid_o, csr_illegal_o;
  logic [1:0] csr_priv_i;
  logic [6:0] csr_addr_i;
  logic [31:0] csr_wdata_i, csr_rdata_o, q;
  logic req_valid_i, req_first_i, req_modify_privilege_bit_i, req_ptw_i;
  logic [33:0] req_addr_i;
  logic [1:0] req_size_i, req_type_i, req_priv_i, req_mpp_i;
  logic rsp_valid_o, rsp_allow_o, rsp_insn_fault_o;
  logic [2:0] rsp_fault_o;
  logic [5:0] r;
  int fail_count = 0;
  int compares = 0;
  pmpc_row_t rows [18] = '{
    '{16'h0000, 0, 0, 34'h100, 2, 1, 0, 0, 0, 0},
    '{16'h0000, 0, 0, 34'h100, 2, 0, 3, 0, 0, 1},
    '{16'h0019, 32'h403, 0, 34'h1010, 2, 1, 0, 0, 0, 1},
    '{16'h0019, 32'h403, 0, 34'h1010, 2, 2, 0, 0, 0, 0},
    '{16'h0019, 32'h403, 0, 34'h1010, 2, 0, 0, 0, 0, 0},
    '{16'h0019, 32'h403, 0, 34'h1020, 0, 1, 0, 0, 0, 0},
    '{16'h0019, 32'h403, 0, 34'h101C, 3, 1, 1, 0, 0, 0},
    '{16'h0019, 32'h403, 0, 34'h1010, 2, 2, 3, 0, 0, 1},
    '{16'h0019, 32'h403, 0, 34'h2000, 2, 1, 3, 1, 0, 0},
    '{16'h0019, 32'h403, 0, 34'h2000, 2, 1, 3, 0, 1, 0},
    '{16'h0019, 32'h403, 0, 34'h1000, 2, 1, 3, 0, 1, 1},
    '{16'h0B00, 32'h800, 32'hC03, 34'h2FFC, 2, 2, 0, 0, 0, 1},
    '{16'h0B00, 32'h800, 32'hC03, 34'h3000, 2, 2, 0, 0, 0, 0},
    '{16'h0B00, 32'hC00, 32'h800, 34'h2800, 2, 1, 0, 0, 0, 0},
    '{16'h000C, 32'h400, 0, 34'h0, 2, 0, 0, 0, 0, 1},
    '{16'h1F18, 32'h403, 32'h3FF, 34'h1000, 2, 1, 0, 0, 0, 0},
    '{16'h1F18, 32'h403, 32'h3FF, 34'h1100, 2, 0, 1, 0, 0, 1},
    '{16'h0019, 32'h8000_0003, 0, 34'h2_0000_0010, 2, 1, 0, 0, 0, 1}
  };
  pmpc_checker u_pmpc_checker (.clk_sys_i, .sys_rst_i, .ce_i, .csr_we_i, .csr_re_i,
    .csr_priv_i, .csr_addr_i, .csr_wdata_i, .csr_rdata_o, .csr_rvalid_o, .csr_illegal_o,
    .req_valid_i, .req_first_i, .req_addr_i, .req_size_i, .req_type_i, .req_priv_i,
    .req_modify_privilege_bit_i, .req_mpp_i, .req_ptw_i, .rsp_valid_o, .rsp_allow_o, .rsp_fault_o,
    .rsp_insn_fault_o);
  pmpc_hart_model u_pmpc_hart_model (.clk_sys_i, .req_valid_o(req_valid_i),
    .req_first_o(req_first_i), .req_addr_o(req_addr_i), .req_size_o(req_size_i),
    .req_type_o(req_type_i), .req_priv_o(req_priv_i), .req_modify_privilege_bit_o(req_modify_privilege_bit_i),
    .req_mpp_o(req_mpp_i), .req_ptw_o(req_ptw_i), .rsp_valid_i(rsp_valid_o),
    .rsp_allow_i(rsp_allow_o), .rsp_fault_i(rsp_fault_o), .rsp_insn_fault_i(rsp_insn_fault_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic csr_op(input logic we, input logic [6:0] a, input logic [31:0] d,
    input logic ill);
    @(posedge clk_sys_i);
    #1;
    {csr_we_i, csr_re_i, csr_addr_i, csr_wdata_i} = {we, !we, a, d};
    @(posedge clk_sys_i);
    #1;
    {csr_we_i, csr_re_i} = 2'b00;
    q = csr_rdata_o;
    chk("illegal", ill, csr_illegal_o);
    chk("rvalid", !we && !ill, csr_rvalid_o);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    csr_op(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    csr_op(1'b0, a, 32'h0, 1'b0);
    chk("rdata", e, q);
  endtask
  task automatic acc(input logic [33:0] a, input logic [1:0] ty, input logic [1:0] pv,
    input logic fi);
    u_pmpc_hart_model.access(a, 2'h2, ty, pv, 1'b0, 1'b0, fi, r);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {sys_rst_i, ce_i, csr_we_i, csr_re_i, csr_addr_i, csr_wdata_i} = {2'b11, 41'h0};
    csr_priv_i = 2'h3;
    repeat (16) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    foreach (rows[i]) begin
      wr(7'h40, rows[i].a0);
      wr(7'h41, rows[i].a1);
      wr(7'h00, {16'h0, rows[i].c});
      u_pmpc_hart_model.access(rows[i].ad, rows[i].sz, rows[i].ty, rows[i].pv, rows[i].mp,
        rows[i].pt, 1'b1, r);
      chk("valid", 1'b1, r[5]);
      chk("allow", rows[i].ok, r[4]);
      chk("fault", rows[i].ok ? 3'h0 : 3'h1 << rows[i].ty, r[3:1]);
    end
    $display("test table done");
    wr(7'h00, 32'h19);
    wr(7'h00, 32'h12);
    rd(7'h00, 32'h19);
    wr(7'h00, 32'h0);
    wr(7'h40, 32'h2);
    rd(7'h40, 32'h0);
    wr(7'h00, 32'h18);
    rd(7'h40, 32'h3);
    wr(7'h00, 32'h0);
    wr(7'h00, 32'h18);
    rd(7'h40, 32'h3);
    csr_priv_i = 2'h0;
    csr_op(1'b1, 7'h40, 32'h55, 1'b1);
    csr_priv_i = 2'h3;
    rd(7'h40, 32'h3);
    csr_op(1'b0, 7'h20, 32'h0, 1'b1);
    wr(7'h01, 32'h1F0F0B19);
    rd(7'h01, 32'h1F0F0B19);
    wr(7'h04, 32'hFFFF);
    rd(7'h04, 32'h0);
    $display("test registers done");
    wr(7'h40, 32'h403);
    wr(7'h00, 32'h19);
    acc(34'h1010, 2'h1, 2'h0, 1'b1);
    chk("insn", 1'b0, r[0]);
    acc(34'h1010, 2'h2, 2'h0, 1'b0);
    chk("insn", 1'b1, r[0]);
    acc(34'h1010, 2'h1, 2'h0, 1'b0);
    chk("insn", 1'b1, {r[4], r[0]} === 2'b11);
    acc(34'h1010, 2'h1, 2'h0, 1'b1);
    chk("insn", 1'b0, r[0]);
    $display("test instruction done");
    wr(7'h40, 32'h800);
    wr(7'h41, 32'hC00);
    wr(7'h00, 32'h8C00);
    wr(7'h40, 32'h0);
    wr(7'h41, 32'h100);
    wr(7'h00, 32'h0);
    rd(7'h40, 32'h800);
    rd(7'h41, 32'hC00);
    rd(7'h00, 32'h8C00);
    acc(34'h2000, 2'h1, 2'h3, 1'b1);
    chk("locked load", 1'b0, r[4]);
    acc(34'h2000, 2'h0, 2'h3, 1'b1);
    chk("locked fetch", 1'b1, r[4]);
    $display("test lock done");
    @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    rd(7'h00, 32'h0);
    rd(7'h41, 32'h0);
    acc(34'h2000, 2'h1, 2'h0, 1'b1);
    chk("after reset", 1'b0, r[4]);
    $display("test reset done");
    @(posedge clk_sys_i);
    #1 {ce_i, csr_we_i, csr_addr_i, csr_wdata_i} = {2'b01, 7'h40, 32'h7F0};
    @(posedge clk_sys_i);
    #1 {ce_i, csr_we_i} = 2'b10;
    rd(7'h40, 32'h0);
    wr(7'h40, 32'h7F0);
    rd(7'h40, 32'h7F0);
    $display("test enable done");
    final_report();
  end
  initial begin
    #2_000_000;
    fail_count++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
